// ---- pll_cal_regs.sv ----
// clock multiplier calibration and trim register bank
`timescale 1ns/1ps
module pll_cal_regs
  import pll_cal_pkg::*;
#(
  parameter int DIV = CAL_DIV
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire reg_req_t reg_req, // register access from the serial port
  input wire logic cp_comp_high, // calibration comparator output
  output logic [7:0] reg_rdata, // read data, one cycle after rd
  output pll_trim_t trim, // trim fields to the analog side
  output logic [3:0] cp_code, // code driving the charge pump
  output logic cal_clk_en, // calibration clock enable pulse
  output logic sequencer_on // power-up sequencer enabled
);

  // =====================================================================
  // stored fields
  logic [7:0] ctrl;
  logic [3:0] manual;
  logic [4:0] bias;
  logic [7:0] prsc;
  logic [3:0] refr;
  logic [7:0] next_ctrl;
  logic [3:0] next_manual;
  logic [4:0] next_bias;
  logic [7:0] next_prsc;
  logic [3:0] next_refr;
  logic [7:0] next_rdata;
  seq_state_t state;
  logic [3:0] cp_cal_result;
  logic cal_done;
  logic machine_en;
  logic override;
  logic wr_ctrl;
  logic wr_bias;
  logic wr_prsc;
  logic wr_ref;

  assign machine_en = ctrl[CTRL_MACHINE];
  assign override = ctrl[CTRL_OVERRIDE];
  assign sequencer_on = machine_en;
  assign wr_ctrl = reg_req.wr && reg_req.addr == ADDR_CTRL;
  assign wr_bias = reg_req.wr && reg_req.addr == ADDR_BIAS;
  assign wr_prsc = reg_req.wr && reg_req.addr == ADDR_PRSC;
  assign wr_ref = reg_req.wr && reg_req.addr == ADDR_REF;

  // =====================================================================
  // write decode; reserved bits are not stored
  always_comb begin
    next_ctrl = ctrl;
    next_manual = manual;
    next_bias = bias;
    next_prsc = prsc;
    next_refr = refr;
    if (wr_ctrl) begin
      next_ctrl = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == ADDR_SEQ) begin
      next_manual = reg_req.wdata[3:0];
    end
    if (wr_bias) begin
      next_bias = reg_req.wdata[4:0];
    end
    if (wr_prsc) begin
      next_prsc = reg_req.wdata;
    end
    if (wr_ref) begin
      next_refr = reg_req.wdata[3:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= RST_CTRL;
      manual <= RST_MANUAL;
      bias <= RST_BIAS;
      prsc <= RST_PRSC;
      refr <= RST_REF;
    end else begin
      ctrl <= next_ctrl;
      manual <= next_manual;
      bias <= next_bias;
      prsc <= next_prsc;
      refr <= next_refr;
    end
  end

  // =====================================================================
  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_STATUS: next_rdata = {2'h0, cal_done, 1'b0, cp_cal_result};
        ADDR_CTRL: next_rdata = ctrl;
        ADDR_SEQ: next_rdata = {state, manual};
        ADDR_BIAS: next_rdata = {3'h0, bias};
        ADDR_PRSC: next_rdata = prsc;
        ADDR_REF: next_rdata = {4'h0, refr};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // =====================================================================
  // trim outputs
  always_comb begin
    trim = '0;
    trim.dither = ctrl[CTRL_DITHER];
    trim.cp_offset_off = ctrl[CTRL_CPOFF];
    trim.cp_test = ctrl[1:0];
    trim.vco_bias_tempco = bias[4:3];
    trim.vco_bias_ref = bias[2:0];
    trim.vco_bias_resistor_skip = prsc[PRSC_BIASR];
    trim.prsc_spare = prsc[6:5];
    trim.vco_comparator_resistor_skip = prsc[PRSC_COMPR];
    trim.prsc_high_r = prsc[3];
    trim.last_alc_en = prsc[2];
    trim.prsc_bias = prsc[1:0];
    trim.calref_monitor = refr[REF_MON];
    trim.vco_calref_tempco = refr[2:0];
  end

  // =====================================================================
  // charge-pump code selection
  // override picks manual code
  assign cp_code = (override || !machine_en) ? manual : cp_cal_result;

  // =====================================================================
  // calibration clock and sequencer
  // halved calibration clock
  cal_clock_div #(
    .DIV(DIV)
  ) u_div (
    .mclk(mclk),
    .arst_n(arst_n),
    .run(state == SEQ_CAL),
    .halve(ctrl[CTRL_HALVE]),
    .tick(cal_clk_en)
  );

  cp_cal_seq u_seq (
    .mclk(mclk),
    .arst_n(arst_n),
    .machine_en(machine_en),
    .cal_en(ctrl[CTRL_CALEN]),
    .tick(cal_clk_en),
    .cp_comp_high(cp_comp_high),
    .state(state),
    .cp_cal_result(cp_cal_result),
    .cal_done(cal_done)
  );

  // =====================================================================
  // helper flags: register written since reset
  logic seen_ctrl;
  logic seen_bias;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seen_ctrl <= 1'b0;
      seen_bias <= 1'b0;
    end else begin
      seen_ctrl <= seen_ctrl | wr_ctrl;
      seen_bias <= seen_bias | wr_bias;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // =====================================================================
  // checks
  machine_default_a: assert property (!seen_ctrl |-> machine_en && !override && !ctrl[CTRL_HALVE])
    else $error("control register left its reset value unwritten");
  auto_code_a: assert property ((machine_en && !override) |-> cp_code == cp_cal_result)
    else $error("calibrated code not driving charge pump");
  manual_drive_a: assert property ((!machine_en || override) |-> cp_code == manual)
    else $error("manual code not driving charge pump");
  tempco_default_a: assert property (!seen_bias |-> trim.vco_bias_tempco == RST_BIAS_TEMPCO)
    else $error("bias tempco lost its reset value");
  bias_skip_a: assert property (wr_prsc |=> trim.vco_bias_resistor_skip == $past(reg_req.wdata[PRSC_BIASR]))
    else $error("bias resistor bypass not stored");
  comp_skip_a: assert property (wr_prsc |=> trim.vco_comparator_resistor_skip == $past(reg_req.wdata[PRSC_COMPR]))
    else $error("comparator resistor bypass not stored");
  calref_store_a: assert property (wr_ref |=> ##1 trim.vco_calref_tempco == $past(reg_req.wdata[2:0], 2)
    || $past(wr_ref))
    else $error("reference tempco not stored");
  override_read_a: assert property ((reg_req.rd && reg_req.addr == ADDR_CTRL && !wr_ctrl)
    |=> reg_rdata[CTRL_OVERRIDE] == $past(override))
    else $error("override bit reads back wrong");
  reserved_zero_a: assert property ((reg_req.rd && reg_req.addr == ADDR_REF) |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
  cal_sync_a: assert property ($rose(cal_done) |-> state == SEQ_DONE && machine_en)
    else $error("calibration done outside sequencer");

  override_cover_c: cover property (override && machine_en && cal_done);
  seq_off_cover_c: cover property ($fell(machine_en));
  unmapped_cover_c: cover property (reg_req.rd && reg_req.addr > ADDR_REF);

endmodule

// ---- pll_cal_pkg.sv ----
// constants and types for the clock multiplier calibration register bank
// =====================================================================
// Function
// - Bit 5 of the calibration control register enables the power-up sequencer and resets to one.
// - The running sequencer calibrates the charge pump itself and keeps the 4-bit result for readback.
// - Override bit 3, reset zero, selects the software code instead of the calibrated code.
// - A 4-bit field, reset zero, holds the manual charge-pump code used whenever the sequencer is off.
// - Bit 7, reset zero, halves the rate of the calibration clock when set.
// - Bits 4 to 3 of the bias register hold the VCO bias temperature coefficient, reset to one.
// - Bit 7 of the prescaler register, reset zero, bypasses the VCO bias resistor.
// - Bit 4 of the prescaler register, reset zero, bypasses the VCO comparator resistor.
// - Bits 2 to 0 of the reference register hold the calibration reference temperature coefficient, reset zero.
// - A read/write bit, reset zero, picks automatic or manual charge-pump calibration while the device is off; the code has no such bit.
package pll_cal_pkg;

  // =====================================================================
  // register offsets
  localparam logic [8:0] ADDR_STATUS = 9'h1B8;
  localparam logic [8:0] ADDR_CTRL = 9'h1B9;
  localparam logic [8:0] ADDR_SEQ = 9'h1BA;
  localparam logic [8:0] ADDR_BIAS = 9'h1BB;
  localparam logic [8:0] ADDR_PRSC = 9'h1BC;
  localparam logic [8:0] ADDR_REF = 9'h1BD;

  // =====================================================================
  // field positions
  localparam int CTRL_HALVE = 7;
  localparam int CTRL_DITHER = 6;
  localparam int CTRL_MACHINE = 5;
  localparam int CTRL_CPOFF = 4;
  localparam int CTRL_OVERRIDE = 3;
  localparam int CTRL_CALEN = 2;
  localparam int STATUS_DONE = 5;
  localparam int PRSC_BIASR = 7;
  localparam int PRSC_COMPR = 4;
  localparam int REF_MON = 3;

  // =====================================================================
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h34;
  localparam logic [3:0] RST_MANUAL = 4'h0;
  localparam logic [4:0] RST_BIAS = 5'h0C;
  localparam logic [7:0] RST_PRSC = 8'h00;
  localparam logic [3:0] RST_REF = 4'h0;
  localparam logic [1:0] RST_BIAS_TEMPCO = 2'h1;

  // =====================================================================
  // timing: base calibration clock period in system clock cycles
  localparam int CAL_DIV = 4;

  // sequencer states, one-hot, read back as the machine state field
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_CAL = 4'h2,
    SEQ_DONE = 4'h4,
    SEQ_OFF = 4'h8
  } seq_state_t;

  // register access request from the serial port decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // trim fields driven into the analog clock multiplier
  typedef struct packed {
    logic dither;
    logic cp_offset_off;
    logic [1:0] cp_test;
    logic [1:0] vco_bias_tempco;
    logic [2:0] vco_bias_ref;
    logic vco_bias_resistor_skip;
    logic [1:0] prsc_spare;
    logic vco_comparator_resistor_skip;
    logic prsc_high_r;
    logic last_alc_en;
    logic [1:0] prsc_bias;
    logic calref_monitor;
    logic [2:0] vco_calref_tempco;
  } pll_trim_t;

endpackage

// ---- cal_clock_div.sv ----
// calibration clock enable divider with optional halving
`timescale 1ns/1ps
module cal_clock_div
  import pll_cal_pkg::*;
#(
  parameter int DIV = CAL_DIV
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic run, // divider enabled
  input wire logic halve, // vco_cal_clock_halve
  output logic tick // one-cycle calibration clock enable
);

  localparam int CW = $clog2(2 * DIV + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] limit;
  logic [CW-1:0] gap;

  // =====================================================================
  // divider
  // period doubles
  assign limit = halve ? CW'(2 * DIV - 1) : CW'(DIV - 1);
  assign tick = run && (cnt >= limit);

  // next count
  always_comb begin
    next_cnt = cnt;
    if (!run || tick) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  // count register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // helper: cycles since last tick
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap <= '0;
    end else if (tick || !run) begin
      gap <= '0;
    end else begin
      gap <= gap + CW'(1);
    end
  end

  // =====================================================================
  // checks
  tick_period_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (tick && $past(run) && $past(tick) == 1'b0 && gap != '0 && $stable(halve))
      |-> gap == (halve ? CW'(2 * DIV - 1) : CW'(DIV - 1)))
    else $error("calibration tick period wrong");
  halved_cover_c: cover property (@(posedge mclk) disable iff (!arst_n) tick && halve);

endmodule

// ---- cp_cal_seq.sv ----
// power-up sequencer with successive-approximation charge-pump calibration
`timescale 1ns/1ps
module cp_cal_seq
  import pll_cal_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic machine_en, // sequencer enable
  input wire logic cal_en, // charge-pump calibration enable
  input wire logic tick, // calibration clock enable
  input wire logic cp_comp_high, // comparator: trial code too high
  output seq_state_t state, // sequencer state
  output logic [3:0] cp_cal_result, // stored calibration code
  output logic cal_done // calibration has completed
);

  seq_state_t next_state;
  logic [3:0] next_result;
  logic [1:0] bit_idx;
  logic [1:0] next_bit_idx;
  logic next_done;
  logic [3:0] trial;

  // current trial code sets the bit under test
  assign trial = cp_cal_result | (4'h1 << bit_idx);

  // =====================================================================
  // next state and search
  always_comb begin
    next_state = state;
    next_result = cp_cal_result;
    next_bit_idx = bit_idx;
    next_done = cal_done;
    case (state)
      SEQ_OFF: begin
        if (machine_en) begin
          next_state = SEQ_IDLE;
        end
      end
      SEQ_IDLE: begin
        if (!machine_en) begin
          next_state = SEQ_OFF;
        end else if (cal_en) begin
          next_state = SEQ_CAL;
          next_result = 4'h0;
          next_bit_idx = 2'h3;
          next_done = 1'b0;
        end else begin
          next_state = SEQ_DONE;
        end
      end
      SEQ_CAL: begin
        if (!machine_en) begin
          next_state = SEQ_OFF;
        end else if (tick) begin
          next_result = cp_comp_high ? cp_cal_result : trial;
          if (bit_idx == 2'h0) begin
            next_state = SEQ_DONE;
            next_done = 1'b1;
          end else begin
            next_bit_idx = bit_idx - 2'h1;
          end
        end
      end
      SEQ_DONE: begin
        if (!machine_en) begin
          next_state = SEQ_OFF;
        end
      end
      default: begin
        next_state = SEQ_OFF;
      end
    endcase
  end

  // state registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SEQ_OFF;
      cp_cal_result <= 4'h0;
      bit_idx <= 2'h3;
      cal_done <= 1'b0;
    end else begin
      state <= next_state;
      cp_cal_result <= next_result;
      bit_idx <= next_bit_idx;
      cal_done <= next_done;
    end
  end

  // =====================================================================
  // checks
  result_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (state == SEQ_DONE && $past(state) == SEQ_DONE) |-> $stable(cp_cal_result))
    else $error("calibration result changed after completion");
  cal_cover_c: cover property (@(posedge mclk) disable iff (!arst_n) $rose(cal_done));

endmodule

// ---- tb_pll_cal_regs.sv ----
// self-checking testbench for the calibration register bank
`timescale 1ns/1ps
module tb_pll_cal_regs;
  import pll_cal_pkg::*;
  localparam int DIV_TB = 2;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t reg_req = '0;
  logic cp_comp_high;
  logic [7:0] reg_rdata;
  pll_trim_t trim;
  logic [3:0] cp_code;
  logic cal_clk_en;
  logic sequencer_on;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int last_tick = 0;
  int tick_cnt = 0;
  int gap [0:3];
  logic [3:0] pat = 4'h0;
  logic [31:0] seed = 32'h130AE464;
  logic [7:0] q;
  logic [7:0] q0;
  logic [8:0] a;
  logic [7:0] d;

  // =====================================================================
  // clock and design
  always #2.5 mclk = ~mclk;

  pll_cal_regs #(.DIV(DIV_TB)) dut_u (
    .mclk(mclk),
    .arst_n(arst_n),
    .reg_req(reg_req),
    .cp_comp_high(cp_comp_high),
    .reg_rdata(reg_rdata),
    .trim(trim),
    .cp_code(cp_code),
    .cal_clk_en(cal_clk_en),
    .sequencer_on(sequencer_on)
  );

  // count calibration ticks and the spacing between them
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cal_clk_en === 1'b1) begin
      if (tick_cnt < 4) gap[tick_cnt] <= cyc - last_tick;
      last_tick <= cyc;
      tick_cnt <= tick_cnt + 1;
    end
  end

  // comparator answers from the chosen pattern, msb decision first
  assign cp_comp_high = (tick_cnt < 4) ? pat[3 - tick_cnt] : 1'b0;

  // =====================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // readback expected after writing d to a stored register
  function automatic logic [7:0] exp_rd(input logic [8:0] ad, input logic [7:0] dv);
    case (ad)
      ADDR_BIAS: exp_rd = dv & 8'h1F;
      ADDR_REF: exp_rd = dv & 8'h0F;
      default: exp_rd = dv;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [8:0] ad, input logic [7:0] dv);
    @(posedge mclk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: dv};
    @(posedge mclk);
    reg_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [8:0] ad, output logic [7:0] dv);
    @(posedge mclk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    dv = reg_rdata;
  endtask

  // restart the sequencer and check the calibrated code and tick spacing
  task automatic calibrate(input logic [3:0] p, input logic halve);
    int n;
    logic [7:0] v;
    wr(ADDR_CTRL, {halve, 7'h04});
    @(posedge mclk);
    tick_cnt <= 0;
    pat <= p;
    wr(ADDR_CTRL, {halve, 7'h24});
    n = 0;
    while (tick_cnt < 4 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 500) begin
      err_total++;
      report_and_stop();
    end
    repeat (3) @(posedge mclk);
    #1;
    rd(ADDR_STATUS, v);
    chk(v, {2'b00, 1'b1, 1'b0, ~p});
    rd(ADDR_SEQ, v);
    chk({4'h0, v[7:4]}, 8'h04);
    chk({4'h0, cp_code}, {4'h0, ~p});
    for (int k = 1; k < 4; k++) begin
      chk(8'(gap[k]), 8'(DIV_TB * (halve ? 2 : 1)));
    end
  endtask

  // =====================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    #1;
    // defaults after reset
    chk({7'h00, sequencer_on}, 8'h01);
    chk({6'h00, trim.vco_bias_tempco}, 8'h01);
    rd(ADDR_CTRL, q);
    chk(q, 8'h34);
    rd(ADDR_SEQ, q);
    chk(q & 8'h0F, 8'h00);
    rd(ADDR_BIAS, q);
    chk(q, 8'h0C);
    rd(ADDR_PRSC, q);
    chk(q, 8'h00);
    rd(ADDR_REF, q);
    chk(q, 8'h00);
    // calibrations, corner pattern first, halving alternated
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      calibrate((i == 0) ? 4'hF : seed[3:0], i[0]);
    end
    calibrate(4'h0, 1'b1);
    // manual code with override, then with the sequencer off
    wr(ADDR_SEQ, 8'hFA);
    rd(ADDR_SEQ, q);
    chk(q & 8'h0F, 8'h0A);
    wr(ADDR_CTRL, 8'h2C);
    chk({4'h0, cp_code}, 8'h0A);
    wr(ADDR_CTRL, 8'h04);
    chk({4'h0, cp_code}, 8'h0A);
    chk({7'h00, sequencer_on}, 8'h00);
    rd(ADDR_SEQ, q);
    chk({4'h0, q[7:4]}, 8'h08);
    // random writes and readback of stored fields
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      a = ADDR_CTRL + 9'(seed[31:16] % 5);
      d = seed[7:0];
      wr(a, d);
      rd(a, q);
      if (a == ADDR_SEQ) begin
        chk(q & 8'h0F, d & 8'h0F);
      end else begin
        chk(q, exp_rd(a, d));
      end
      if (a == ADDR_PRSC) begin
        chk({6'h00, trim.vco_bias_resistor_skip, trim.vco_comparator_resistor_skip}, {6'h00, d[7], d[4]});
      end
      if (a == ADDR_BIAS) begin
        chk({6'h00, trim.vco_bias_tempco}, {6'h00, d[4:3]});
      end
      if (a == ADDR_REF) begin
        chk({5'h00, trim.vco_calref_tempco}, {5'h00, d[2:0]});
      end
    end
    // read-only status and unmapped places ignore writes
    wr(ADDR_CTRL, 8'h04);
    rd(ADDR_STATUS, q0);
    wr(ADDR_STATUS, ~q0);
    rd(ADDR_STATUS, q);
    chk(q, q0);
    wr(9'h1C0, 8'h5A);
    rd(9'h1C0, q);
    chk(q, 8'h00);
    report_and_stop();
  end
endmodule
